/* rtl/smclw_top.sv */
// Stop mode clock loss handling and wake-up control with register slave
//
// Contract
// - Monitor on, no self-clock: immediate monitor reset
// - Loss with self-clock: regulator, PLL, check, flag
// - Good after 4096 edges: leave self-clock, stay
// - Recovered, wake interrupt: exit on oscillator clock
// - Recovered, external reset: exit, start reset sequence
// - Still failed, interrupt off: stay, keep checking
// - Interrupt while failed: exit in self-clock, check
// - Reset while failed: exit in self-clock, reset, check
// - Self-clock interrupt enabled: flag itself wakes device
// - Full stop ends only by external interrupt/reset
// - Reset in full stop: defaults, 50 windows, reset
// - Interrupt wake: up to 50 windows, then run
// - All windows fail: self-clock or monitor reset
// - Stop clears PLL select; software sets it again
// - Monitor disabled during full stop
// - Monitor off: clock loss ignored
// - Stop type one is pseudo, zero is full
`timescale 1ns/1ps
`default_nettype none
module smclw_top #(
   parameter int WIN_CYC = smclw_pkg::SMCLW_WIN_CYC_DFLT
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        stop_req_i,
   input  wire logic        wake_irq_i,
   input  wire logic        osc_clk_i,
   input  wire logic        ext_reset_n_i,
   input  wire logic        ext_irq_i,
   output logic             stop_active_o,
   output logic             self_clock_mode_o,
   output logic             sys_from_pll_o,
   output logic             pll_en_o,
   output logic             voltage_regulator_en_o,
   output logic             clock_monitor_reset_o,
   output logic             reset_seq_start_o,
   output logic             irq_o
);
   import smclw_pkg::*;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   // Bit 0 oscillator, bit 1 reset pin, bit 2 external interrupt
   logic [2:0] pin_s1;
   logic [2:0] pin_s2;
   logic [1:0] pin_d;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_s1 <= 3'h2;
         pin_s2 <= 3'h2;
         pin_d  <= 2'h2;
      end else begin
         pin_s1 <= {ext_irq_i, ext_reset_n_i, osc_clk_i};
         pin_s2 <= pin_s1;
         pin_d  <= pin_s2[1:0];
      end
   end

   wire osc_edge    = pin_s2[0] && !pin_d[0];
   wire ext_rst_evt = !pin_s2[1] && pin_d[1];
   wire ext_irq     = pin_s2[2];

   // ****************************************************************
   // Registers and state
   // ****************************************************************
   smclw_state_t state;
   smclw_state_t next_state;
   logic         clock_monitor_enable;
   logic         self_clock_mode_enable;
   logic         stop_type_select;
   logic         pll_clock_select;
   logic         self_clock_irq_enable;
   logic         self_clock_irq_flag;
   logic         scm_act;
   logic         wake_by_rst;
   logic [5:0]   fail_cnt;
   logic [6:0]   loss_cnt;
   logic         next_scm_act;
   logic         next_wake_by_rst;
   logic [5:0]   next_fail_cnt;
   logic         ev_cmrst;
   logic         ev_seq;
   logic         ev_flag;
   logic         ev_dflt;
   logic         pll_clr;
   logic         qc_good;
   logic         qc_fail;

   // ****************************************************************
   // Clock monitor
   // ****************************************************************
   // Counts clock cycles since the last oscillator edge, saturating
   always_ff @(posedge clk_i) begin
      if (rst_i || osc_edge) begin
         loss_cnt <= '0;
      end else if (loss_cnt != 7'(SMCLW_LOSS_CYC)) begin
         loss_cnt <= loss_cnt + 7'h1;
      end
   end

   wire osc_lost = (loss_cnt == 7'(SMCLW_LOSS_CYC));
   // Only watched in pseudo-stop; full stop has no monitor
   wire mon_fail = osc_lost && clock_monitor_enable && (state == SMCLW_PSTOP);

   // ****************************************************************
   // Quality checker
   // ****************************************************************
   // Full stop halts any running check; wake-up restarts it clean
   wire qc_run = (scm_act && (state != SMCLW_FSTOP)) ||
                 (state == SMCLW_FWAKE);

   smclw_qcheck #(
      .WIN_CYC    (WIN_CYC)
   ) u_qcheck (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .run_i      (qc_run),
      .osc_edge_i (osc_edge),
      .good_o     (qc_good),
      .win_fail_o (qc_fail)
   );

   wire last_win = (fail_cnt == 6'(SMCLW_FSTOP_MAX_WIN - 1));

   // ****************************************************************
   // Mode sequencer
   // ****************************************************************
   always_comb begin
      next_state       = state;
      next_scm_act     = scm_act;
      next_fail_cnt    = fail_cnt;
      next_wake_by_rst = wake_by_rst;
      ev_cmrst         = 1'b0;
      ev_seq           = 1'b0;
      ev_flag          = 1'b0;
      ev_dflt          = 1'b0;
      pll_clr          = 1'b0;
      if (qc_good) begin
         next_scm_act = 1'b0;
      end
      unique case (state)
         SMCLW_RUN: begin
            if (ext_rst_evt) begin
               ev_seq  = 1'b1;
               ev_dflt = 1'b1;
            end else if (stop_req_i) begin
               pll_clr    = 1'b1;
               next_state = stop_type_select ? SMCLW_PSTOP : SMCLW_FSTOP;
            end
         end
         SMCLW_PSTOP: begin
            if (ext_rst_evt) begin
               ev_seq     = 1'b1;
               ev_dflt    = 1'b1;
               next_state = SMCLW_RUN;
            end else if (mon_fail && !self_clock_mode_enable) begin
               ev_cmrst = 1'b1;
            end else if (mon_fail && !scm_act) begin
               next_scm_act = 1'b1;
               ev_flag      = 1'b1;
            end else if (wake_irq_i) begin
               next_state = SMCLW_RUN;
            end else if (scm_act && self_clock_irq_flag && self_clock_irq_enable) begin
               next_state = SMCLW_RUN;
            end
         end
         SMCLW_FSTOP: begin
            // Internal wake sources are ignored here
            next_fail_cnt = '0;
            if (ext_rst_evt) begin
               next_state       = SMCLW_FWAKE;
               next_wake_by_rst = 1'b1;
               ev_dflt          = 1'b1;
            end else if (ext_irq) begin
               next_state       = SMCLW_FWAKE;
               next_wake_by_rst = 1'b0;
            end
         end
         SMCLW_FWAKE: begin
            if (qc_good) begin
               next_state = SMCLW_RUN;
               ev_seq     = wake_by_rst;
            end else if (qc_fail && last_win) begin
               next_state = SMCLW_RUN;
               if (self_clock_mode_enable) begin
                  next_scm_act = 1'b1;
                  ev_seq       = wake_by_rst;
               end else begin
                  ev_cmrst = 1'b1;
               end
            end else if (qc_fail) begin
               next_fail_cnt = fail_cnt + 6'h1;
            end
         end
      endcase
      // Monitor reset restores defaults, so self-clock mode follows
      if (ev_cmrst) begin
         next_state   = SMCLW_RUN;
         next_scm_act = 1'b1;
         ev_dflt      = 1'b1;
         ev_seq       = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state       <= SMCLW_RUN;
         scm_act     <= 1'b0;
         fail_cnt    <= '0;
         wake_by_rst <= 1'b0;
      end else begin
         state       <= next_state;
         scm_act     <= next_scm_act;
         fail_cnt    <= next_fail_cnt;
         wake_by_rst <= next_wake_by_rst;
      end
   end

   // ****************************************************************
   // Wishbone slave
   // ****************************************************************
   // Writes land on the edge where ack is high; one wait state
   wire wb_req    = wb_cyc_i && wb_stb_i;
   wire wb_wr     = wb_req && wb_we_i && wb_ack_o && wb_sel_i[0];
   wire wr_ctrl   = wb_wr && (wb_adr_i == SMCLW_ADR_CTRL);
   wire wr_stat   = wb_wr && (wb_adr_i == SMCLW_ADR_STAT);
   wire wr_mask   = wb_wr && (wb_adr_i == SMCLW_ADR_MASK);
   wire flag_clr  = wr_stat && wb_dat_i[SMCLW_IRQ_SCM];

   wire [31:0] rd_ctrl  = {28'h0, pll_clock_select, stop_type_select, self_clock_mode_enable, clock_monitor_enable};
   wire [31:0] rd_stat  = {31'h0, self_clock_irq_flag};
   wire [31:0] rd_mask  = {31'h0, self_clock_irq_enable};
   wire [31:0] rd_state = {27'h0, pll_en_o, voltage_regulator_en_o, scm_act, state};
   wire [31:0] rd_data  =
      (wb_adr_i == SMCLW_ADR_CTRL)  ? rd_ctrl  :
      (wb_adr_i == SMCLW_ADR_STAT)  ? rd_stat  :
      (wb_adr_i == SMCLW_ADR_MASK)  ? rd_mask  :
      (wb_adr_i == SMCLW_ADR_STATE) ? rd_state : 32'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req && !wb_ack_o;
         wb_dat_o <= rd_data;
      end
   end

   // ****************************************************************
   // Configuration and flag
   // ****************************************************************
   // Hardware restore and stop entry win over a same-cycle write
   always_ff @(posedge clk_i) begin
      if (rst_i || ev_dflt) begin
         clock_monitor_enable   <= SMCLW_CME_RST;
         self_clock_mode_enable  <= SMCLW_SELF_CLOCK_MODE_ENABLE_RST;
         stop_type_select  <= SMCLW_STOP_TYPE_SELECT_RST;
         self_clock_irq_enable <= SMCLW_SELF_CLOCK_IRQ_ENABLE_RST;
      end else begin
         if (wr_ctrl) begin
            clock_monitor_enable  <= wb_dat_i[SMCLW_CTRL_CME];
            self_clock_mode_enable <= wb_dat_i[SMCLW_CTRL_SELF_CLOCK_MODE_ENABLE];
            stop_type_select <= wb_dat_i[SMCLW_CTRL_STOP_TYPE_SELECT];
         end
         if (wr_mask) begin
            self_clock_irq_enable <= wb_dat_i[SMCLW_IRQ_SCM];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || ev_dflt || pll_clr) begin
         pll_clock_select <= SMCLW_PLLS_RST;
      end else if (wr_ctrl) begin
         pll_clock_select <= wb_dat_i[SMCLW_CTRL_PLLS];
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         self_clock_irq_flag <= 1'b0;
      end else begin
         self_clock_irq_flag <= ev_flag || (self_clock_irq_flag && !flag_clr);
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   wire run_now = (next_state == SMCLW_RUN);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stop_active_o         <= 1'b0;
         self_clock_mode_o     <= 1'b0;
         sys_from_pll_o        <= 1'b0;
         pll_en_o              <= 1'b1;
         voltage_regulator_en_o             <= 1'b1;
         clock_monitor_reset_o <= 1'b0;
         reset_seq_start_o     <= 1'b0;
         irq_o                 <= 1'b0;
      end else begin
         stop_active_o         <= !run_now;
         self_clock_mode_o     <= next_scm_act;
         sys_from_pll_o        <= run_now && !next_scm_act && pll_clock_select &&
                                  !pll_clr && !ev_dflt;
         pll_en_o              <= run_now || next_scm_act;
         voltage_regulator_en_o             <= run_now || next_scm_act;
         clock_monitor_reset_o <= ev_cmrst;
         reset_seq_start_o     <= ev_seq;
         irq_o                 <= self_clock_irq_flag && self_clock_irq_enable;
      end
   end

endmodule // smclw_top
`default_nettype wire

/* inc/smclw_pkg.sv */
// Constants and types for the stop mode clock loss and wake-up controller
package smclw_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] SMCLW_ADR_CTRL  = 8'h00;
   localparam logic [7:0] SMCLW_ADR_STAT  = 8'h04;
   localparam logic [7:0] SMCLW_ADR_MASK  = 8'h08;
   localparam logic [7:0] SMCLW_ADR_STATE = 8'h0C;

   // Control register fields
   localparam int SMCLW_CTRL_CME   = 0;
   localparam int SMCLW_CTRL_SELF_CLOCK_MODE_ENABLE  = 1;
   localparam int SMCLW_CTRL_STOP_TYPE_SELECT  = 2;
   localparam int SMCLW_CTRL_PLLS  = 3;
   // Status and mask share one layout
   localparam int SMCLW_IRQ_SCM    = 0;

   // Values after reset
   localparam logic SMCLW_CME_RST   = 1'b1;
   localparam logic SMCLW_SELF_CLOCK_MODE_ENABLE_RST  = 1'b1;
   localparam logic SMCLW_STOP_TYPE_SELECT_RST  = 1'b0;
   localparam logic SMCLW_PLLS_RST  = 1'b0;
   localparam logic SMCLW_SELF_CLOCK_IRQ_ENABLE_RST = 1'b0;

   // ****************************************************************
   // Counts
   // ****************************************************************
   localparam int SMCLW_OSC_GOOD_CNT  = 4096;
   localparam int SMCLW_FSTOP_MAX_WIN = 50;
   localparam int SMCLW_LOSS_CYC      = 64;
   localparam int SMCLW_WIN_CYC_DFLT  = 16384;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      SMCLW_RUN,
      SMCLW_PSTOP,
      SMCLW_FSTOP,
      SMCLW_FWAKE
   } smclw_state_t;

endpackage

/* rtl/smclw_qcheck.sv */
// Clock quality checker: counts oscillator edges inside check windows
`timescale 1ns/1ps
`default_nettype none
module smclw_qcheck #(
   parameter int WIN_CYC = smclw_pkg::SMCLW_WIN_CYC_DFLT
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic run_i,
   input  wire logic osc_edge_i,
   output logic      good_o,
   output logic      win_fail_o
);
   import smclw_pkg::*;

   // ****************************************************************
   // Counters
   // ****************************************************************
   logic [31:0] win_cnt;
   logic [12:0] osc_cnt;
   wire         osc_done;
   wire         win_done;

   assign osc_done = osc_edge_i &&
                     (osc_cnt == 13'(SMCLW_OSC_GOOD_CNT - 1));
   assign win_done = (win_cnt == 32'(WIN_CYC - 1));

   // Dropping run clears both counts, so each start is a fresh window
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i || osc_done || win_done) begin
         win_cnt <= '0;
         osc_cnt <= '0;
      end else begin
         win_cnt <= win_cnt + 32'h1;
         osc_cnt <= osc_cnt + {12'h0, osc_edge_i};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         good_o     <= 1'b0;
         win_fail_o <= 1'b0;
      end else begin
         good_o     <= run_i && osc_done;
         win_fail_o <= run_i && win_done && !osc_done;
      end
   end

endmodule // smclw_qcheck
`default_nettype wire

/* tb/smclw_osc_model.sv */
// Oscillator source and external reset pin model
`timescale 1ns/1ps
`default_nettype none
module smclw_osc_model (
   input  wire logic clk_i,
   input  wire logic run_i,
   input  wire logic rst_req_i,
   output logic      osc_o = 1'b0,
   output logic      rst_n_o = 1'b1
);
   logic [1:0] cnt  = 2'h0;
   logic [3:0] hold = 4'h0;
   // Period of four clk cycles; a lost clock stands still low
   always_ff @(posedge clk_i) begin
      cnt     <= cnt + 2'h1;
      osc_o   <= run_i & cnt[1];
      hold    <= rst_req_i ? 4'h8 : hold - {3'h0, hold != 4'h0};
      rst_n_o <= (hold == 4'h0);
   end
endmodule // smclw_osc_model
`default_nettype wire

/* tb/smclw_properties.sv */
// Port checker for the stop mode clock loss and wake-up controller
`timescale 1ns/1ps
`default_nettype none
module smclw_properties #(
   parameter int WIN_CYC = 64
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        stop_req_i,
   input wire logic        stop_active_o,
   input wire logic        self_clock_mode_o,
   input wire logic        sys_from_pll_o,
   input wire logic        pll_en_o,
   input wire logic        voltage_regulator_en_o,
   input wire logic        clock_monitor_reset_o
);
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   chk_ack_one_wait: assert property (s_req |=> s_ack)
      else $error("ack not one cycle after request");
   chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i
      && wb_adr_i[7:4] != 4'h0 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_voltage_regulator_pll_tie: assert property (voltage_regulator_en_o == pll_en_o)
      else $error("regulator and pll enables differ");
   chk_scm_on_pll: assert property (self_clock_mode_o |->
      pll_en_o && !sys_from_pll_o)
      else $error("self-clock without pll");
   chk_stop_sel_clr: assert property ($fell(stop_active_o) |->
      !sys_from_pll_o [*2])
      else $error("pll select kept over stop");
   chk_cmr_to_run: assert property (clock_monitor_reset_o |->
      ##[0:1] !stop_active_o)
      else $error("monitor reset left device stopped");
   chk_stop_entry: assert property ($rose(stop_active_o) |->
      $past(stop_req_i))
      else $error("stop without request");
   chk_pstop_idle: assert property (stop_active_o && $past(stop_active_o)
      && !self_clock_mode_o && !$past(self_clock_mode_o) |-> !pll_en_o)
      else $error("pll on in stop without self-clock");
   chk_run_pll_on: assert property (!stop_active_o
      && !$past(stop_active_o) |-> pll_en_o)
      else $error("pll off in run");
endmodule // smclw_properties
bind smclw_top smclw_properties #(.WIN_CYC(WIN_CYC)) smclw_properties_i (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
   .wb_ack_o, .stop_req_i, .stop_active_o, .self_clock_mode_o,
   .sys_from_pll_o, .pll_en_o, .voltage_regulator_en_o, .clock_monitor_reset_o);
`default_nettype wire

/* tb/smclw_top_tb.sv */
// Self-checking bench for the stop mode clock loss and wake-up controller
`timescale 1ns/1ps
`default_nettype none
module smclw_top_tb;
   import smclw_pkg::*;
   // ****************************************************************
   // Short window: good checks cannot pass, fail paths run fast
   // ****************************************************************
   localparam int WIN = 64;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, stop_req_i = 1'b0, wake_irq_i = 1'b0;
   logic ext_irq_i = 1'b0, osc_run = 1'b1, rst_req = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, stop_active_o, self_clock_mode_o, sys_from_pll_o;
   logic pll_en_o, voltage_regulator_en_o, clock_monitor_reset_o, reset_seq_start_o;
   logic irq_o, osc_clk_i, ext_reset_n_i, saw_cmr, saw_seq;
   int failures = 0, n_checks = 0, seed = 40118, cycles = 0, n;
   logic [31:0] expq[$];
   wire logic [3:0] obs = {reset_seq_start_o, clock_monitor_reset_o,
                           self_clock_mode_o, stop_active_o};
   smclw_top #(.WIN_CYC(WIN)) smclw_top_i (.clk_i, .rst_i, .wb_cyc_i,
      .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .stop_req_i, .wake_irq_i, .osc_clk_i, .ext_reset_n_i,
      .ext_irq_i, .stop_active_o, .self_clock_mode_o, .sys_from_pll_o,
      .pll_en_o, .voltage_regulator_en_o, .clock_monitor_reset_o, .reset_seq_start_o,
      .irq_o);
   smclw_osc_model smclw_osc_model_i (.clk_i, .run_i(osc_run),
      .rst_req_i(rst_req), .osc_o(osc_clk_i), .rst_n_o(ext_reset_n_i));
   always #2 clk_i = ~clk_i;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: got %h, want %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      $display("Checks %0d, mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'($random(seed)) | 4'h1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 20);
      check(k < 20, 1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task wait_on(input int b, input logic v, input int lim);
      n = 0;
      while (obs[b] !== v && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      check(n < lim, 1);
   endtask
   task enter_stop(input logic [31:0] c, input logic [31:0] m);
      rst_i   <= 1'b1;
      osc_run <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i   <= 1'b0;
      saw_cmr = 1'b0;
      saw_seq = 1'b0;
      @(posedge clk_i);
      bus(1'b1, SMCLW_ADR_CTRL, c);
      bus(1'b1, SMCLW_ADR_MASK, m);
      check(sys_from_pll_o, c[3]);
      stop_req_i <= 1'b1;
      @(posedge clk_i);
      stop_req_i <= 1'b0;
      osc_run    <= 1'b0;
      repeat (3) @(posedge clk_i);
      check(stop_active_o, 1);
   endtask
   task pulse_wake;
      wake_irq_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      wake_irq_i <= 1'b0;
   endtask
   task fstop(input logic [31:0] c, input logic r);
      enter_stop(c, 0);
      repeat (200 + ($random(seed) & 63)) @(posedge clk_i);
      pulse_wake;
      repeat (10) @(posedge clk_i);
      check({stop_active_o, saw_cmr}, 2'b10);
      rst_req   <= r;
      ext_irq_i <= !r;
      repeat (4) @(posedge clk_i);
      rst_req   <= 1'b0;
      ext_irq_i <= 1'b0;
      wait_on(0, 1'b0, 50 * WIN + 200);
      check(n + 4 >= 49 * WIN, 1);
      // Let the pulse watcher settle; a monitor reset also restores
      // the self-clock enable, so self-clock mode follows either way
      @(posedge clk_i);
      check({self_clock_mode_o, saw_cmr}, {1'b1, !(c[1] | r)});
      if (r) check(saw_seq, 1);
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0)
         check(wb_dat_o, expq.pop_front());
      if (clock_monitor_reset_o === 1'b1) saw_cmr = 1'b1;
      if (reset_seq_start_o === 1'b1) saw_seq = 1'b1;
      if (cycles == 40000) begin
         failures++;
         give_verdict;
      end
   end
   initial begin
      enter_stop(32'hC, 0);
      repeat (200) @(posedge clk_i);
      rd(SMCLW_ADR_STATE, 32'h01);
      rd(SMCLW_ADR_CTRL, 32'h4);
      pulse_wake;
      wait_on(0, 1'b0, 20);
      check({self_clock_mode_o, sys_from_pll_o, saw_cmr}, 3'b000);
      enter_stop(32'h5, 0);
      wait_on(2, 1'b1, 200);
      repeat (3) @(posedge clk_i);
      check({saw_seq, stop_active_o, self_clock_mode_o}, 3'b101);
      rd(SMCLW_ADR_CTRL, 32'h3);
      enter_stop(32'h7, 0);
      wait_on(1, 1'b1, 200);
      repeat (2) @(posedge clk_i);
      check({pll_en_o, voltage_regulator_en_o, stop_active_o, irq_o}, 4'hE);
      repeat (400) @(posedge clk_i);
      check(stop_active_o, 1);
      rd(SMCLW_ADR_STAT, 32'h1);
      pulse_wake;
      wait_on(0, 1'b0, 20);
      check({self_clock_mode_o, sys_from_pll_o}, 2'b10);
      bus(1'b1, SMCLW_ADR_MASK, 32'h1);
      repeat (2) @(posedge clk_i);
      check(irq_o, 1);
      bus(1'b1, SMCLW_ADR_MASK, 32'h0);
      repeat (2) @(posedge clk_i);
      check(irq_o, 0);
      bus(1'b1, SMCLW_ADR_STAT, 32'h1);
      bus(1'b1, 8'h10, 32'hF);
      rd(SMCLW_ADR_STAT, 32'h0);
      rd(8'h10, 32'h0);
      bus(1'b1, SMCLW_ADR_MASK, 32'h1);
      repeat (2) @(posedge clk_i);
      check(irq_o, 0);
      enter_stop(32'h7, 1);
      wait_on(0, 1'b0, 200);
      check({self_clock_mode_o, irq_o}, 2'b11);
      enter_stop(32'h7, 0);
      wait_on(1, 1'b1, 200);
      rst_req <= 1'b1;
      @(posedge clk_i);
      rst_req <= 1'b0;
      wait_on(3, 1'b1, 40);
      repeat (2) @(posedge clk_i);
      check({stop_active_o, self_clock_mode_o}, 2'b01);
      rd(SMCLW_ADR_CTRL, 32'h3);
      fstop(32'h3, 1'b0);
      fstop(32'h1, 1'b0);
      fstop(32'h1, 1'b1);
      give_verdict;
   end
endmodule // smclw_top_tb
`default_nettype wire
